// file: hdl/fco_defines.svh
// Purpose: Offsets, field positions and reset values of the command object block.
// Assumes: APB with 32-bit data; one register per aligned word.
// Notes:   Register indices are word numbers; byte address is four times the index.
`ifndef FCO_DEFINES_SVH
`define FCO_DEFINES_SVH

// Width of the APB address.
`define FCO_AW            12

// Register indices (byte address = index * 4).
`define FCO_IDX_STATUS    6'h00
`define FCO_IDX_OPTION    6'h03
`define FCO_IDX_CMDOBJ0   6'h04
`define FCO_IDX_CMDOBJB   6'h0f
`define FCO_IDX_INTST     6'h10
`define FCO_IDX_INTMSK    6'h11

// Number of command object bytes and their width.
`define FCO_CMDOBJ_COUNT  12
`define FCO_BYTE_W        8

// Field positions.
`define FCO_POS_CMD_DONE  7
`define FCO_POS_EV_DONE   0
`define FCO_POS_EV_LOCK   1
`define FCO_EV_W          2

// Reset values.
`define FCO_RST_OPTION    8'h00
`define FCO_RST_BYTE      8'h00
`define FCO_RST_EV        2'h0

`endif

// file: hdl/fco_pkg.sv
// Purpose: Types shared by the command object block.
// Assumes: fco_defines.svh supplies the widths.
// Notes:   Nothing here is imported; users write fco_pkg::name.
`include "fco_defines.svh"
package fco_pkg;

    typedef struct packed {
        logic                psel;
        logic                penable;
        logic                pwrite;
        logic [`FCO_AW-1:0]  paddr;
        logic [31:0]         pwdata;
    } fco_apb_req_t;

    typedef struct packed {
        logic                   en;
        logic [3:0]             idx;
        logic [`FCO_BYTE_W-1:0] data;
    } fco_eng_wr_t;

    typedef enum logic [1:0] {
        FCO_LOAD,
        FCO_IDLE,
        FCO_BUSY
    } fco_state_t;

endpackage : fco_pkg

// file: hdl/fco_option_load.sv
// Purpose: Captures the nonvolatile option byte once after reset.
// Assumes: The load path presents the byte with a valid strobe on mclk.
// Notes:   There is no write path at all, so software cannot alter it.
`timescale 1ns/1ps
`include "fco_defines.svh"
module fco_option_load (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   srst,
    // Load path from nonvolatile storage
    input  wire logic [`FCO_BYTE_W-1:0] nvOptionByte,
    input  wire logic                   nvOptionValid,
    // Captured option value
    output logic      [`FCO_BYTE_W-1:0] optionValue,
    output logic                        optionLoaded
);

    // The first valid byte after reset wins; later strobes are ignored.
    always_ff @(posedge mclk) begin
        if (srst) begin
            optionValue  <= `FCO_RST_OPTION;
            optionLoaded <= 1'b0;
        end else if (!optionLoaded && nvOptionValid) begin
            optionValue  <= nvOptionByte;
            optionLoaded <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    opt_load_a: assert property (
        !optionLoaded && nvOptionValid |=>
            optionLoaded && optionValue == $past(nvOptionByte))
        else $error("option byte not captured on load strobe");

    opt_hold_a: assert property (
        optionLoaded |=> optionLoaded && $stable(optionValue))
        else $error("option value changed after load");

endmodule : fco_option_load

// file: hdl/fco_byte_mem.sv
// Purpose: Storage for the command object bytes with a registered read port.
// Assumes: One write per cycle; the caller arbitrates writers.
// Notes:   Every byte is also presented flat so the engine sees all of them.
`timescale 1ns/1ps
`include "fco_defines.svh"
module fco_byte_mem #(
    parameter int DEPTH = `FCO_CMDOBJ_COUNT
) (
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         srst,
    // Write port
    input  wire logic                         wrEn,
    input  wire logic [3:0]                   wrIdx,
    input  wire logic [`FCO_BYTE_W-1:0]       wrData,
    // Read port
    input  wire logic                         rdEn,
    input  wire logic [3:0]                   rdIdx,
    output logic      [`FCO_BYTE_W-1:0]       rdData,
    // All bytes, byte 0 in the low lane
    output logic      [DEPTH*`FCO_BYTE_W-1:0] flat
);

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_byte
            always_ff @(posedge mclk) begin
                if (srst) begin
                    flat[i*`FCO_BYTE_W +: `FCO_BYTE_W] <= `FCO_RST_BYTE;
                end else if (wrEn && wrIdx == 4'(i)) begin
                    flat[i*`FCO_BYTE_W +: `FCO_BYTE_W] <= wrData;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdData <= `FCO_RST_BYTE;
        end else if (rdEn) begin
            rdData <= (32'(rdIdx) < DEPTH) ? flat[rdIdx*`FCO_BYTE_W +: `FCO_BYTE_W]
                                           : `FCO_RST_BYTE;
        end
    end

endmodule : fco_byte_mem

// file: hdl/fco_regs.sv
// Purpose: Command staging registers and option register of a flash controller.
// Assumes: APB slave on mclk; engine and option load path share mclk.
// Notes:   Every APB access takes one wait state; reads of locked bytes give zero.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "fco_defines.svh"
module fco_regs #(
    parameter int NBYTES = `FCO_CMDOBJ_COUNT
) (
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          srst,
    // APB slave
    input  wire fco_pkg::fco_apb_req_t         apbReq,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Nonvolatile option byte load path
    input  wire logic [`FCO_BYTE_W-1:0]        nvOptionByte,
    input  wire logic                          nvOptionValid,
    // Command execution engine
    output logic                               cmdStart,
    output logic      [NBYTES*`FCO_BYTE_W-1:0] cmdBytes,
    input  wire fco_pkg::fco_eng_wr_t          engResult,
    input  wire logic                          engDone,
    // Interrupt
    output logic                               irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.

    fco_pkg::fco_state_t          state;
    logic                         cmdDone;
    logic [5:0]                   wordIdx;
    logic [5:0]                   objOff;
    logic [3:0]                   objIdx;
    logic                         upperZero;
    logic                         isStat;
    logic                         isOption;
    logic                         isObj;
    logic                         isIntSt;
    logic                         isIntMk;
    logic                         mapped;
    logic                         setupPh;
    logic                         accessPh;
    logic                         commit;
    logic                         launchWr;

    assign wordIdx   = apbReq.paddr[7:2];
    assign upperZero = (apbReq.paddr[`FCO_AW-1:8] == '0);
    assign objOff    = wordIdx - `FCO_IDX_CMDOBJ0;
    assign objIdx    = objOff[3:0];

    assign isStat  = upperZero && (wordIdx == `FCO_IDX_STATUS);
    assign isOption = upperZero && (wordIdx == `FCO_IDX_OPTION);
    assign isObj   = upperZero && (wordIdx >= `FCO_IDX_CMDOBJ0)
                   && (wordIdx <= `FCO_IDX_CMDOBJB);
    assign isIntSt = upperZero && (wordIdx == `FCO_IDX_INTST);
    assign isIntMk = upperZero && (wordIdx == `FCO_IDX_INTMSK);
    assign mapped  = isStat || isOption || isObj || isIntSt || isIntMk;

    assign setupPh  = apbReq.psel && !apbReq.penable;
    assign accessPh = apbReq.psel && apbReq.penable;
    // A write lands only at the edge where the master sees pready high.
    assign commit   = accessPh && pready && apbReq.pwrite;

    // The done flag is the idle state itself, so it cannot disagree with it.
    assign cmdDone  = (state == fco_pkg::FCO_IDLE);
    assign launchWr = commit && isStat && apbReq.pwdata[`FCO_POS_CMD_DONE]
                    && cmdDone;

    ////////////////////////////////////////////////////////////////////////////
    // Option register.

    logic [`FCO_BYTE_W-1:0] optionValue;
    logic                   optionLoaded;

    // No write path leads here; writes to its index are accepted and dropped.
    fco_option_load u_option (
        .mclk          (mclk),
        .srst          (srst),
        .nvOptionByte  (nvOptionByte),
        .nvOptionValid (nvOptionValid),
        .optionValue   (optionValue),
        .optionLoaded  (optionLoaded)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Command sequencing.

    // The block stays locked until the option load finishes, so no command
    // can start against a half-initialised controller.
    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= fco_pkg::FCO_LOAD;
        end else begin
            unique case (state)
                fco_pkg::FCO_LOAD: begin
                    if (optionLoaded) begin
                        state <= fco_pkg::FCO_IDLE;
                    end
                end
                fco_pkg::FCO_IDLE: begin
                    if (launchWr) begin
                        state <= fco_pkg::FCO_BUSY;
                    end
                end
                fco_pkg::FCO_BUSY: begin
                    if (engDone) begin
                        state <= fco_pkg::FCO_IDLE;
                    end
                end
                default: begin
                    state <= fco_pkg::FCO_LOAD;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cmdStart <= 1'b0;
        end else begin
            cmdStart <= launchWr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command object storage.

    logic                   engWr;
    logic                   swObjWr;
    logic                   memWrEn;
    logic [3:0]             memWrIdx;
    logic [`FCO_BYTE_W-1:0] memWrData;
    logic [`FCO_BYTE_W-1:0] memRdData;

    // Engine and software writers never overlap: one needs busy, one idle.
    assign engWr     = (state == fco_pkg::FCO_BUSY) && engResult.en;
    assign swObjWr   = commit && isObj && cmdDone;
    assign memWrEn   = engWr || swObjWr;
    assign memWrIdx  = engWr ? engResult.idx  : objIdx;
    assign memWrData = engWr ? engResult.data : apbReq.pwdata[`FCO_BYTE_W-1:0];

    fco_byte_mem #(
        .DEPTH (NBYTES)
    ) u_mem (
        .mclk   (mclk),
        .srst   (srst),
        .wrEn   (memWrEn),
        .wrIdx  (memWrIdx),
        .wrData (memWrData),
        .rdEn   (setupPh && isObj),
        .rdIdx  (objIdx),
        .rdData (memRdData),
        .flat   (cmdBytes)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask.

    logic [`FCO_EV_W-1:0] intStatus;
    logic [`FCO_EV_W-1:0] intMask;
    logic [`FCO_EV_W-1:0] events;
    logic [`FCO_EV_W-1:0] clearBits;
    logic [`FCO_EV_W-1:0] next_intStatus;
    logic [`FCO_EV_W-1:0] next_intMask;

    always_comb begin
        events = '0;
        events[`FCO_POS_EV_DONE] = (state == fco_pkg::FCO_BUSY) && engDone;
        // Flags software that a locked byte write was thrown away.
        events[`FCO_POS_EV_LOCK] = commit && isObj && !cmdDone;
        clearBits = (commit && isIntSt) ? apbReq.pwdata[`FCO_EV_W-1:0] : '0;
        // A new event outranks a clear in the same cycle.
        next_intStatus = (intStatus & ~clearBits) | events;
        // The interrupt follows the mask being written, so it never lags it.
        next_intMask = (commit && isIntMk) ? apbReq.pwdata[`FCO_EV_W-1:0] : intMask;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            intStatus <= `FCO_RST_EV;
        end else begin
            intStatus <= next_intStatus;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            intMask <= `FCO_RST_EV;
        end else if (commit && isIntMk) begin
            intMask <= apbReq.pwdata[`FCO_EV_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_intStatus & next_intMask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and APB answer.

    logic [31:0] rdMux;

    always_comb begin
        rdMux = '0;
        if (isStat) begin
            rdMux[`FCO_POS_CMD_DONE] = cmdDone;
        end else if (isOption) begin
            rdMux[`FCO_BYTE_W-1:0] = optionValue;
        end else if (isObj && cmdDone) begin
            // Mid-command contents are partial, so they read as zero.
            rdMux[`FCO_BYTE_W-1:0] = memRdData;
        end else if (isIntSt) begin
            rdMux[`FCO_EV_W-1:0] = intStatus;
        end else if (isIntMk) begin
            rdMux[`FCO_EV_W-1:0] = intMask;
        end
    end

    // One wait state: the stored byte is fetched at setup and lands here.
    always_ff @(posedge mclk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (accessPh && !pready) begin
            pready  <= 1'b1;
            pslverr <= !mapped;
            prdata  <= apbReq.pwrite ? 32'h0 : rdMux;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence setupSeq;
        apbReq.psel && !apbReq.penable;
    endsequence

    sequence accessSeq;
        apbReq.psel && apbReq.penable;
    endsequence

    apb_answer_a: assert property (
        setupSeq ##1 accessSeq |-> !pready ##1 pready)
        else $error("APB answer not after exactly one wait state");

    launch_clear_a: assert property (
        launchWr |=> !cmdDone && cmdStart ##1 !cmdStart && !cmdDone)
        else $error("launch did not clear done flag with one start pulse");

    no_queue_a: assert property (
        commit && isStat && apbReq.pwdata[`FCO_POS_CMD_DONE]
        && state == fco_pkg::FCO_BUSY && !engDone |=> !cmdStart && !cmdDone)
        else $error("second command accepted while one is in progress");

    obj_lock_a: assert property (
        !cmdDone && !engResult.en |=> $stable(cmdBytes))
        else $error("command bytes changed while locked");

    obj_ignore_a: assert property (
        commit && isObj && !cmdDone |=> intStatus[`FCO_POS_EV_LOCK])
        else $error("locked write not flagged as ignored");

    obj_code_a: assert property (
        commit && isObj && cmdDone && objIdx == 4'h0 |=>
            cmdBytes[`FCO_BYTE_W-1:0] == $past(apbReq.pwdata[`FCO_BYTE_W-1:0]))
        else $error("command code byte not stored in byte 0");

    obj_map_a: assert property (
        commit && cmdDone && upperZero && wordIdx == `FCO_IDX_CMDOBJB |=>
            cmdBytes[NBYTES*`FCO_BYTE_W-1 -: `FCO_BYTE_W]
            == $past(apbReq.pwdata[`FCO_BYTE_W-1:0]))
        else $error("last command byte not at its index");

    result_gate_a: assert property (
        accessPh && !pready && !apbReq.pwrite && isObj && !cmdDone
        |=> pready && prdata == 32'h0)
        else $error("command byte readable before completion");

    done_event_a: assert property (
        state == fco_pkg::FCO_BUSY && engDone |=>
            cmdDone && intStatus[`FCO_POS_EV_DONE])
        else $error("completion did not set done flag and event");

    irq_level_a: assert property (
        irq == |(intStatus & intMask))
        else $error("interrupt level does not match unmasked status");

endmodule : fco_regs

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the command staging and option registers.
// Assumes: APB master tasks on mclk; the engine side is driven by hand.
// Notes:   Byte addresses are four times the register index.
`timescale 1ns/1ps
module tb_top;

    localparam logic [11:0] STAT  = 12'h000;
    localparam logic [11:0] NVBIT = 12'h00c;
    localparam logic [11:0] BYTE0 = 12'h010;
    localparam logic [11:0] INTST = 12'h040;
    localparam logic [11:0] MSK   = 12'h044;

    logic                    mclk;
    logic                    srst;
    fco_pkg::fco_apb_req_t   req;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic [7:0]              nvByte;
    logic                    nvValid;
    logic                    cmdStart;
    logic [95:0]             cmdBytes;
    fco_pkg::fco_eng_wr_t    eng;
    logic                    engDone;
    logic                    irq;
    int                      n_fail;
    int                      samples_checked;
    int                      nStarts;

    fco_regs #(.NBYTES(12)) dut (
        .mclk          (mclk),
        .srst          (srst),
        .apbReq        (req),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .nvOptionByte  (nvByte),
        .nvOptionValid (nvValid),
        .cmdStart      (cmdStart),
        .cmdBytes      (cmdBytes),
        .engResult     (eng),
        .engDone       (engDone),
        .irq           (irq)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Launch pulses are counted here so a one-cycle pulse is never missed.
    always @(posedge mclk) begin
        if (srst === 1'b1) begin
            nStarts <= 0;
        end else if (cmdStart === 1'b1) begin
            nStarts <= nStarts + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    task automatic final_report;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Holds the request until pready is sampled high, then releases it.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= a;
        req.pwdata  <= wd;
        @(posedge mclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
        end
        rd = prdata;
        err = pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic        e;
        apb(1'b1, a, wd, d, e);
        chk(e, 1'b0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, d, e);
        chk({e, d}, {1'b0, exp});
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////////

    initial begin
        logic [95:0] expBytes;
        logic [31:0] d;
        logic        e;
        n_fail = 0;
        samples_checked = 0;
        srst = 1'b1;
        req = '0;
        nvByte = 8'h5a;
        nvValid = 1'b0;
        eng = '0;
        engDone = 1'b0;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rd(NVBIT, 32'h0000_0000);
        rd(STAT, 32'h0000_0000);
        nvValid <= 1'b1;
        @(posedge mclk);
        nvValid <= 1'b0;
        repeat (2) @(posedge mclk);
        rd(NVBIT, 32'h0000_005a);
        rd(STAT, 32'h0000_0080);
        // A second load strobe and a software write must both leave the value alone.
        nvByte <= 8'hc3;
        nvValid <= 1'b1;
        @(posedge mclk);
        nvValid <= 1'b0;
        wr(NVBIT, 32'h0000_00ff);
        rd(NVBIT, 32'h0000_005a);
        for (int i = 11; i >= 0; i--) begin
            wr(BYTE0 + 12'(4 * i), 32'hdead_be00 | 32'(8'h10 + i));
        end
        for (int i = 0; i < 12; i++) begin
            rd(BYTE0 + 12'(4 * i), 32'(8'h10 + i));
            expBytes[i*8 +: 8] = 8'(8'h10 + i);
        end
        chk(cmdBytes, expBytes);
        apb(1'b0, 12'h048, 32'h0000_0000, d, e);
        chk({e, d}, {1'b1, 32'h0000_0000});
        for (int c = 0; c < 2; c++) begin
            wr(MSK, (c == 0) ? 32'h0000_0003 : 32'h0000_0001);
            wr(STAT, 32'h0000_0080);
            rd(STAT, 32'h0000_0000);
            chk(nStarts, c + 1);
            wr(BYTE0, 32'h0000_00ee);
            wr(STAT, 32'h0000_0080);
            rd(BYTE0, 32'h0000_0000);
            chk(nStarts, c + 1);
            chk(cmdBytes, expBytes);
            rd(INTST, 32'h0000_0002);
            chk(irq, (c == 0) ? 1'b1 : 1'b0);
            eng <= '{en: 1'b1, idx: 4'd3, data: 8'(8'h77 + c)};
            @(posedge mclk);
            eng <= '0;
            engDone <= 1'b1;
            @(posedge mclk);
            engDone <= 1'b0;
            expBytes[31:24] = 8'(8'h77 + c);
            repeat (3) @(posedge mclk);
            rd(STAT, 32'h0000_0080);
            rd(BYTE3_ADDR(), 32'(8'h77 + c));
            rd(BYTE0, 32'h0000_0010);
            chk(cmdBytes, expBytes);
            rd(INTST, 32'h0000_0003);
            chk(irq, 1'b1);
            wr(INTST, 32'h0000_0003);
            rd(INTST, 32'h0000_0000);
            chk(irq, 1'b0);
        end
        // Engine writes outside a command have no effect.
        eng <= '{en: 1'b1, idx: 4'd5, data: 8'h99};
        @(posedge mclk);
        eng <= '0;
        rd(BYTE0 + 12'h014, 32'h0000_0015);
        // A reset in mid-run clears the bytes and reloads the option byte.
        srst <= 1'b1;
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rd(STAT, 32'h0000_0000);
        chk(cmdBytes, 96'h0);
        nvValid <= 1'b1;
        @(posedge mclk);
        nvValid <= 1'b0;
        repeat (2) @(posedge mclk);
        rd(NVBIT, 32'h0000_00c3);
        rd(STAT, 32'h0000_0080);
        final_report();
    end

    function automatic logic [11:0] BYTE3_ADDR();
        return BYTE0 + 12'h00c;
    endfunction : BYTE3_ADDR

    // The whole sequence needs well under two thousand cycles.
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        final_report();
    end

endmodule : tb_top
